/* File: verilog/ctp_pkg.sv */
// Purpose: Shared constants for the compliance test pattern select block
// Assumes: APB register bus, 32-bit data, one aligned word per register
// Notes:   Register indices are word indices; byte address is four times the index
`default_nettype none
package ctp_pkg;
   // ==========================================================================
   // Register map
   localparam logic [11:0] CTP_IDX_CONFIG  = 12'h027;  // compliance_test_config
   localparam logic [11:0] CTP_IDX_EXT     = 12'h428;  // extended 100BASE-TX control
   localparam logic [11:0] CTP_IDX_STATUS  = 12'h040;  // block status, read only
   localparam int          CTP_ADDR_W      = 14;
   localparam logic [15:0] CTP_CONFIG_RST  = 16'h0000;
   localparam logic [15:0] CTP_EXT_RST     = 16'h0000;

   // ==========================================================================
   // Field positions
   localparam int CTP_EN_BIT     = 4;   // enable in both registers
   localparam int CTP_TOP_BIT    = 5;   // top code bit in extended register
   localparam int CTP_PAT_LSB    = 0;
   localparam int CTP_PAT_W      = 4;
   localparam int CTP_CODE_W     = 5;

   // ==========================================================================
   // Pattern codes
   localparam logic [3:0] CTP_PAT_LAST_DEFINED = 4'hc;  // above this is reserved

   typedef enum logic [1:0] {
      CTP_S_IDLE  = 2'b00,
      CTP_S_ONE   = 2'b01,
      CTP_S_ZEROS = 2'b11,
      CTP_S_CLEAR = 2'b10
   } ctp_state_t;
endpackage
`default_nettype wire

/* File: verilog/ctp_compliance_test.sv */
// Purpose: Compliance test pattern selection and 100BASE-TX one-then-zeros generator
// Assumes: APB slave on pclk, one line bit per pclk in the 100BASE-TX generator
//          pstrb lanes 2 and 3 have nothing behind them
// Notes:   The 10BASE-T pattern itself is produced by the 10M transmitter from
//          the selected code; this block selects, gates and reports it.
//          Link speed must already be forced by software; nothing here checks it.
//          The 100M enable must stay low for one clock before it is set again.
// Operation
// - Config bit 4 set starts the selected defined 10BASE-T pattern instead of traffic
// - Extended register bit 4 set enables 100BASE-TX test mode with five-bit code
// - Four-bit field chooses one of thirteen defined 10BASE-T patterns
// - 100BASE-TX code is ext bit 5 over field; send one then that many zeros
// - 100BASE-TX code of zero clears the pattern shift register
// - Compliance test config register resets to zero, no pattern selected
`timescale 1ns/1ps
`default_nettype none
module ctp_compliance_test
   import ctp_pkg::*;
(
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [CTP_ADDR_W-1:0] paddr,
   input  wire logic [31:0]           pwdata,
   input  wire logic [3:0]            pstrb,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   output logic                       tx10_test_en,
   output logic      [3:0]            tx10_pattern,
   output logic                       tx100_test_en,
   output logic                       tx100_bit
);

   // ==========================================================================
   // APB decode
   logic [15:0]           config_r;
   logic [15:0]           ext_r;
   logic [CTP_CODE_W-1:0] code_r;
   logic [CTP_CODE_W-1:0] zero_cnt_r;
   logic                  ext_en_d_r;
   logic                  cleared_r;
   ctp_state_t            state_r;
   ctp_state_t            state_nxt;

   logic [11:0] widx;
   logic        hit_cfg;
   logic        hit_ext;
   logic        hit_sts;
   logic        mapped;
   logic        access;
   logic        wr_cfg;
   logic        wr_ext;
   logic [15:0] status;
   logic        reserved_code;

   // Word decode; the two low address bits feed only the error check and the write gating
   assign widx    = paddr[CTP_ADDR_W-1:2];
   assign hit_cfg = (widx == CTP_IDX_CONFIG);
   assign hit_ext = (widx == CTP_IDX_EXT);
   assign hit_sts = (widx == CTP_IDX_STATUS);
   assign mapped  = hit_cfg | hit_ext | hit_sts;
   assign access  = psel & penable;
   // Zero wait state slave; errors only on unmapped words or misaligned addresses
   assign pready  = 1'b1;
   assign pslverr = access & (~mapped | (paddr[1:0] != 2'b00));
   assign wr_cfg  = access & pwrite & hit_cfg & (paddr[1:0] == 2'b00);
   assign wr_ext  = access & pwrite & hit_ext & (paddr[1:0] == 2'b00);

   // ==========================================================================
   // Registers; byte lanes above bit 15 are ignored
   // Compliance test config: all sixteen bits are storage, the low five act
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         config_r <= CTP_CONFIG_RST;
      end else if (wr_cfg) begin
         if (pstrb[0]) config_r[7:0]  <= pwdata[7:0];
         if (pstrb[1]) config_r[15:8] <= pwdata[15:8];
      end
   end

   // Extended control: bit 4 enables the 100M generator, bit 5 tops the code
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_r <= CTP_EXT_RST;
      end else if (wr_ext) begin
         if (pstrb[0]) ext_r[7:0]  <= pwdata[7:0];
         if (pstrb[1]) ext_r[15:8] <= pwdata[15:8];
      end
   end

   // ==========================================================================
   // 10BASE-T selection
   // Reserved codes still pass to the transmitter, but the enable is held off
   // so no undefined waveform reaches the line.
   // Limitation: a reserved code still shows on the pattern output.
   assign reserved_code = (config_r[CTP_PAT_LSB +: CTP_PAT_W] > CTP_PAT_LAST_DEFINED);

   // Registered together so the transmitter never pairs a new enable with an old code
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx10_test_en <= 1'b0;
         tx10_pattern <= 4'h0;
      end else begin
         tx10_test_en <= config_r[CTP_EN_BIT] & ~reserved_code;
         tx10_pattern <= config_r[CTP_PAT_LSB +: CTP_PAT_W];
      end
   end

   // ==========================================================================
   // 100BASE-TX code capture
   // The code is taken only on the rising edge of the enable, so a new code
   // written while running has no effect until the enable is cycled.
   // The generator runs from the delayed enable, so the code is settled first.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_en_d_r <= 1'b0;
         code_r     <= '0;
      end else begin
         ext_en_d_r <= ext_r[CTP_EN_BIT];
         if (ext_r[CTP_EN_BIT] && !ext_en_d_r) begin
            code_r <= {ext_r[CTP_TOP_BIT], config_r[CTP_PAT_LSB +: CTP_PAT_W]};
         end
      end
   end

   // ==========================================================================
   // 100BASE-TX generator state
   // Next state; a dropped enable always returns the generator to idle
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         CTP_S_IDLE: begin
            // Wait for the delayed enable; the code is latched by then
            if (ext_en_d_r) begin
               state_nxt = (code_r == '0) ? CTP_S_CLEAR : CTP_S_ONE;
            end
         end
         CTP_S_ONE: begin
            // One line bit of one, then the zero run
            state_nxt = ext_en_d_r ? CTP_S_ZEROS : CTP_S_IDLE;
         end
         CTP_S_ZEROS: begin
            // A dropped enable wins over the end of the zero run
            if (!ext_en_d_r) begin
               state_nxt = CTP_S_IDLE;
            end else if (zero_cnt_r == code_r) begin
               state_nxt = CTP_S_ONE;
            end
         end
         CTP_S_CLEAR: begin
            // Code zero only clears; the line holds at zero until the enable drops
            if (!ext_en_d_r) state_nxt = CTP_S_IDLE;
         end
         default: state_nxt = CTP_S_IDLE;
      endcase
   end

   // Generator state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= CTP_S_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Zero counter: counts zeros already sent after the one
   // Five bits reach the longest run of thirty-one; it clears outside the run
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         zero_cnt_r <= '0;
      end else if (state_nxt == CTP_S_ZEROS) begin
         zero_cnt_r <= zero_cnt_r + 5'h01;
      end else begin
         zero_cnt_r <= '0;
      end
   end

   // Line bit and shift-register-cleared flag
   // Taken from the next state so line bit and state change on one edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx100_bit     <= 1'b0;
         tx100_test_en <= 1'b0;
         cleared_r     <= 1'b0;
      end else begin
         tx100_bit     <= (state_nxt == CTP_S_ONE);
         tx100_test_en <= ext_en_d_r;
         cleared_r     <= (state_nxt == CTP_S_CLEAR);
      end
   end

   // ==========================================================================
   // Read data
   // Status layout, read only; writes to it are dropped without error
   assign status = {5'h00,           // [15:11] unused
                    reserved_code,   // [10] reserved 10M code held off
                    cleared_r,       // [9] shift register cleared
                    code_r,          // [8:4] latched 100M code
                    state_r,         // [3:2] generator state
                    tx100_test_en,   // [1]
                    tx10_test_en};   // [0]

   // Unmapped words read as zero so stale data never leaks out
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         // Captured in the setup cycle, valid through the access cycle
         if (widx == CTP_IDX_CONFIG)      prdata <= {16'h0000, config_r};
         else if (widx == CTP_IDX_EXT)    prdata <= {16'h0000, ext_r};
         else if (widx == CTP_IDX_STATUS) prdata <= {16'h0000, status};
         else                             prdata <= 32'h0000_0000;
      end
   end

endmodule // ctp_compliance_test
`default_nettype wire

/* File: verif/ctp_line_mon.sv */
// Purpose: Line-side test equipment, measures zero runs on the 100M line
// Assumes: One line bit per pclk
// Notes:   Reports the run that ended at the latest one
`timescale 1ns/1ps
`default_nettype none
module ctp_line_mon (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       line,
   output logic      [5:0] zeros
);
   logic [5:0] cnt_r;
   // ==========================================================================
   // Zero counter; wraps at 64, beyond the longest legal run of 31
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
         zeros <= '0;
      end else if (line) begin
         zeros <= cnt_r;
         cnt_r <= '0;
      end else
         cnt_r <= cnt_r + 6'h01;
   end
endmodule  // ctp_line_mon
`default_nettype wire

/* File: verif/ctp_chk_asserts.sv */
// Purpose: Port assertions for the compliance test pattern block
// Assumes: One pclk domain, zero wait state APB
// Notes:   Ties each test output to the write that caused it
`timescale 1ns/1ps
`default_nettype none
module ctp_chk_asserts
   import ctp_pkg::*;
(
   input wire logic                  pclk,
   input wire logic                  presetn,
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [CTP_ADDR_W-1:0] paddr,
   input wire logic [31:0]           pwdata,
   input wire logic [3:0]            pstrb,
   input wire logic                  pslverr,
   input wire logic                  tx10_test_en,
   input wire logic [3:0]            tx10_pattern,
   input wire logic                  tx100_test_en,
   input wire logic                  tx100_bit
);
   // ==========================================================================
   // Decoded register writes
   wire wr = psel && penable && pwrite && pstrb[0];
   wire wcfg = wr && paddr == {CTP_IDX_CONFIG, 2'b00};
   wire wext = wr && paddr == {CTP_IDX_EXT, 2'b00};
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_en10;
      wcfg |-> ##2
         tx10_test_en == $past(pwdata[4] && pwdata[3:0] <= CTP_PAT_LAST_DEFINED, 2);
   endproperty
   a_en10: assert property (p_en10) else $error("10M enable wrong");
   property p_pat10;
      wcfg |-> ##2 tx10_pattern == $past(pwdata[3:0], 2);
   endproperty
   a_pat10: assert property (p_pat10) else $error("10M pattern wrong");
   property p_resv;
      tx10_test_en |-> tx10_pattern <= CTP_PAT_LAST_DEFINED;
   endproperty
   a_resv: assert property (p_resv) else $error("reserved code enabled");
   property p_en100;
      wext && pwdata[4] && !tx100_test_en |-> ##3 tx100_test_en;
   endproperty
   a_en100: assert property (p_en100) else $error("100M enable late");
   property p_off100;
      wext && !pwdata[4] |-> ##3 !tx100_test_en && !tx100_bit;
   endproperty
   a_off100: assert property (p_off100) else $error("100M did not stop");
   property p_zero;
      $rose(tx100_bit) |=> !tx100_bit;
   endproperty
   a_zero: assert property (p_zero) else $error("one not followed by zero");
   property p_rst;
      $rose(presetn) |-> !tx10_test_en && !tx100_test_en && !tx100_bit;
   endproperty
   a_rst: assert property (p_rst) else $error("test active after reset");
   // Main scenarios reached
   c_10m: cover property (wcfg && pwdata[4]);
   c_100m: cover property ($rose(tx100_test_en));
   c_err: cover property (psel && penable && pslverr);
endmodule  // ctp_chk_asserts
`default_nettype wire

/* File: verif/tb_compliance_test_pattern_select.sv */
// Purpose: Self-checking bench for the compliance test pattern block
// Assumes: APB master on pclk, line monitor on the 100M bit stream
// Notes:   Byte strobes held at all lanes except for one lane-1-only write
`timescale 1ns/1ps
`default_nettype none
module tb_compliance_test_pattern_select
   import ctp_pkg::*;
;
   logic                  pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [CTP_ADDR_W-1:0] paddr = '0;
   logic [31:0]           pwdata = '0, prdata, rd;
   logic [3:0]            pstrb = 4'hf, tx10_pattern;
   logic                  pready, pslverr, tx10_test_en, tx100_test_en, tx100_bit, er;
   logic [5:0]            zeros;
   int                    miscompares = 0, num_checks = 0;
   localparam logic [13:0] A_CFG = {CTP_IDX_CONFIG, 2'b00};
   localparam logic [13:0] A_EXT = {CTP_IDX_EXT, 2'b00};
   localparam logic [13:0] A_SPEED = 14'h0000;  // basic_mode_control, outside this block
   // Rows: enable expected in bit 4, pattern code below
   logic [4:0] tab [16] = '{5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17,
                            5'h18, 5'h19, 5'h1a, 5'h1b, 5'h1c, 5'h0d, 5'h0e, 5'h0f};
   ctp_compliance_test DUT (
      .pclk          (pclk),
      .presetn       (presetn),
      .psel          (psel),
      .penable       (penable),
      .pwrite        (pwrite),
      .paddr         (paddr),
      .pwdata        (pwdata),
      .pstrb         (pstrb),
      .prdata        (prdata),
      .pready        (pready),
      .pslverr       (pslverr),
      .tx10_test_en  (tx10_test_en),
      .tx10_pattern  (tx10_pattern),
      .tx100_test_en (tx100_test_en),
      .tx100_bit     (tx100_bit)
   );
   ctp_line_mon u_mon (.clk(pclk), .rst_n(presetn), .line(tx100_bit), .zeros(zeros));
   always #5 pclk = ~pclk;
   // ==========================================================================
   // Shared tasks
   task automatic test_done;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   // One APB transfer; starts a fresh edge so strobes never toggle twice
   task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1;
      for (k = 0; k < 9; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (k == 9) begin
         miscompares++;
         test_done;
      end
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // Clear the enable, load a code, enable again
   task automatic run100(input logic [4:0] n);
      apb(1, A_EXT, 32'h0);
      apb(1, A_CFG, {28'h0, n[3:0]});
      apb(1, A_EXT, {26'h0, n[4], 5'h10});
   endtask
   task automatic seen(input int e);
      repeat (2 * e + 8) @(posedge pclk);
      #1 chk("zero_run", zeros, e);
      chk("tx100_en", tx100_test_en, 1);
   endtask
   // ==========================================================================
   // Main sequence
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1;
      apb(0, A_CFG, 32'h0);
      chk("config", rd, 32'h0);
      apb(0, A_EXT, 32'h0);
      chk("ext", rd, 32'h0);
      // Speed forcing lands outside this block, so its slot answers with an error
      apb(1, A_SPEED, 32'h0);
      chk("speed_elsewhere", er, 1);
      $display("reset test done");
      foreach (tab[i]) begin
         apb(1, A_CFG, {28'h1, tab[i][3:0]});
         @(posedge pclk);
         #1 chk("tx10_en", tx10_test_en, tab[i][4]);
         chk("tx10_pat", tx10_pattern, tab[i][3:0]);
      end
      $display("10M table test done");
      foreach (tab[i]) if (i < 3) begin
         run100(i == 2 ? 5'd31 : 5'(i + 1));
         seen(i == 2 ? 31 : i + 1);
      end
      apb(1, A_CFG, 32'h5);  // Ignored while enabled
      seen(31);
      run100(5'd0);
      repeat (40) @(posedge pclk);
      #1 chk("cleared_line", tx100_bit, 0);
      apb(0, {CTP_IDX_STATUS, 2'b00}, 32'h0);
      chk("cleared_flag", rd[9], 1);
      apb(0, 14'h0004, 32'h0);
      chk("unmapped", {er, rd[30:0]}, 32'h80000000);
      $display("100M test done");
      // Mid-run reset with both test modes active
      run100(5'd1);
      apb(1, A_CFG, 32'h13);
      repeat (2) @(posedge pclk);
      presetn <= 0;
      #1 chk("rst_tx10_en", tx10_test_en, 0);
      chk("rst_tx100", {tx100_test_en, tx100_bit}, 0);
      repeat (2) @(posedge pclk);
      presetn <= 1;
      apb(0, A_CFG, 32'h0);
      chk("rst_config", rd, 32'h0);
      apb(0, A_EXT, 32'h0);
      chk("rst_ext", rd, 32'h0);
      $display("mid-run reset test done");
      // Upper byte lane only, then a misaligned write that must be refused
      pstrb <= 4'h2;
      apb(1, A_CFG, 32'h0000_ab1f);
      pstrb <= 4'hf;
      apb(1, A_CFG + 14'h0001, 32'h0000_0013);
      chk("misaligned_err", er, 1);
      apb(0, A_CFG, 32'h0);
      chk("lanes_kept", rd, 32'h0000_ab00);
      chk("lane1_no_10m", tx10_test_en, 0);
      $display("awkward test done");
      test_done;
   end
endmodule  // tb_compliance_test_pattern_select
bind ctp_compliance_test ctp_chk_asserts u_chk (
   .pclk          (pclk),
   .presetn       (presetn),
   .psel          (psel),
   .penable       (penable),
   .pwrite        (pwrite),
   .paddr         (paddr),
   .pwdata        (pwdata),
   .pstrb         (pstrb),
   .pslverr       (pslverr),
   .tx10_test_en  (tx10_test_en),
   .tx10_pattern  (tx10_pattern),
   .tx100_test_en (tx100_test_en),
   .tx100_bit     (tx100_bit)
);
`default_nettype wire
